// ---- logic/chan_switch_cfg.svh ----
// Offsets, field positions, reset values and timing for the channel switch.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone register bus.
`ifndef CHAN_SWITCH_CFG_SVH
`define CHAN_SWITCH_CFG_SVH

`define OFS_HARDWARE_CONFIG_REG 8'h00
`define OFS_CHANNEL_SWITCH_REG  8'h04
`define OFS_PIN_LEVEL_STATUS    8'h08
`define OFS_IRQ_MASK_REG        8'h0c
`define OFS_STATE_REG           8'h10

`define COMBINE_SELECT_BIT      0
`define COMBINE_SELECT_RESET    1'b0
`define SWITCH_BITS_RESET       4'h0
`define IRQ_MASK_RESET          4'h0

`define CLK_PERIOD_NS           10
`define FALLBACK_ACT_TIME_NS    2000
`define FALLBACK_ACT_CYCLES \
  ((`FALLBACK_ACT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- logic/chan_switch_pkg.sv ----
// Types shared by the channel input switch matrix.
// Assumes the configuration header is included by the design files.
package chan_switch_pkg;

  typedef enum logic [2:0] {
    OP_SLEEP,
    OP_STANDBY,
    OP_READY,
    OP_ACTIVE,
    OP_FALLBACK
  } op_state_type;

endpackage

// ---- logic/pin_sync.sv ----
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin is driven from outside the core clock domain.
`timescale 1ns/1ps

module pin_sync (
  input  wire logic CORE_CLK_I,
  input  wire logic SYS_RST_I,
  input  wire logic pin_i,
  output logic      level_o
);

  logic meta;
  logic stage2;
  logic stage3;

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      meta   <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      meta   <= pin_i;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      level_o <= 1'b0;
    end else if (stage2 == stage3) begin
      level_o <= stage3;
    end
  end

endmodule

// ---- logic/fallback_qual.sv ----
// Qualifies the fallback pin: asserts after it stays high past a time.
// Assumes a synchronised input on the core clock.
`timescale 1ns/1ps

module fallback_qual #(
  parameter int unsigned ACT_CYCLES = 200
) (
  input  wire logic CORE_CLK_I,
  input  wire logic SYS_RST_I,
  input  wire logic level_i,
  output logic      qualified_o
);

  localparam int CW = $clog2(ACT_CYCLES + 2);

  logic [CW-1:0] count;

  // Counter restarts on every low level so only a continuous high counts
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !level_i) begin
      count <= '0;
    end else if (count <= CW'(ACT_CYCLES)) begin
      count <= count + CW'(1);
    end
  end

  assign qualified_o = level_i && (count > CW'(ACT_CYCLES));

  AST_FALLBACK_NEEDS_HIGH: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(qualified_o) |-> $past(level_i, 2))
    else $error("fallback qualified without a sustained high");

  AST_FALLBACK_DROPS: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !level_i |-> !qualified_o ##1 (count == '0 || level_i))
    else $error("fallback counter not restarted on low");

endmodule

// ---- logic/chan_switch_matrix.sv ----
// Channel input switch matrix with Wishbone register access.
// Assumes pins arrive asynchronously and the bus runs on CORE_CLK_I.
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"

module chan_switch_matrix #(
  parameter int unsigned CHANNELS   = 4,
  parameter int unsigned ACT_CYCLES = `FALLBACK_ACT_CYCLES
) (
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   SYS_RST_I,
  input  wire logic [7:0]             WB_ADR_I,
  input  wire logic [31:0]            WB_DAT_I,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic                   WB_WE_I,
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  output logic      [31:0]            WB_DAT_O,
  output logic                        WB_ACK_O,
  input  wire logic [CHANNELS-1:0]    DIRECT_CHANNEL_PIN_I,
  input  wire logic                   FALLBACK_PIN_I,
  output logic      [CHANNELS-1:0]    CHANNEL_ON_O,
  output chan_switch_pkg::op_state_type OP_STATE_O,
  output logic                        IRQ_O
);

  import chan_switch_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [CHANNELS-1:0] pin_level;
  logic                fallback_level;
  logic                fallback_ok;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_sync
      pin_sync u_sync (
        .CORE_CLK_I (CORE_CLK_I),
        .SYS_RST_I  (SYS_RST_I),
        .pin_i      (DIRECT_CHANNEL_PIN_I[g]),
        .level_o    (pin_level[g])
      );
    end
  endgenerate

  pin_sync u_fb_sync (
    .CORE_CLK_I (CORE_CLK_I),
    .SYS_RST_I  (SYS_RST_I),
    .pin_i      (FALLBACK_PIN_I),
    .level_o    (fallback_level)
  );

  fallback_qual #(.ACT_CYCLES(ACT_CYCLES)) u_qual (
    .CORE_CLK_I  (CORE_CLK_I),
    .SYS_RST_I   (SYS_RST_I),
    .level_i     (fallback_level),
    .qualified_o (fallback_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic                hardware_config_reg;
  logic [CHANNELS-1:0] channel_switch_bit_n;
  logic [CHANNELS-1:0] pin_level_status_reg;
  logic [CHANNELS-1:0] irq_mask;
  op_state_type        op_state;
  logic                bus_req;
  logic                wr_en;
  logic                rd_status;
  logic [31:0]         next_rdata;

  // Single-cycle answer: ack one edge after the request, dropped next cycle
  assign bus_req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_en     = bus_req && WB_WE_I && WB_SEL_I[0];
  assign rd_status = bus_req && !WB_WE_I &&
                     (WB_ADR_I == `OFS_PIN_LEVEL_STATUS);

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    case (WB_ADR_I)
      `OFS_HARDWARE_CONFIG_REG: begin
        next_rdata[`COMBINE_SELECT_BIT] = hardware_config_reg;
      end
      `OFS_CHANNEL_SWITCH_REG: begin
        next_rdata[CHANNELS-1:0] = channel_switch_bit_n;
      end
      `OFS_PIN_LEVEL_STATUS: begin
        next_rdata[CHANNELS-1:0] = pin_level_status_reg;
      end
      `OFS_IRQ_MASK_REG: begin
        next_rdata[CHANNELS-1:0] = irq_mask;
      end
      `OFS_STATE_REG: begin
        next_rdata[2:0] = op_state;
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      WB_DAT_O <= 32'h0;
    end else if (bus_req && !WB_WE_I) begin
      WB_DAT_O <= next_rdata;
    end
  end

  // Register access over the documented serial port is modelled by this
  // parallel slave; the frame layer sits in front of it.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      hardware_config_reg <= `COMBINE_SELECT_RESET;
    end else if (wr_en && WB_ADR_I == `OFS_HARDWARE_CONFIG_REG) begin
      hardware_config_reg <= WB_DAT_I[`COMBINE_SELECT_BIT];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      channel_switch_bit_n <= CHANNELS'(`SWITCH_BITS_RESET);
    end else if (wr_en && WB_ADR_I == `OFS_CHANNEL_SWITCH_REG) begin
      channel_switch_bit_n <= WB_DAT_I[CHANNELS-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      irq_mask <= CHANNELS'(`IRQ_MASK_RESET);
    end else if (wr_en && WB_ADR_I == `OFS_IRQ_MASK_REG) begin
      irq_mask <= WB_DAT_I[CHANNELS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin-high flags, cleared on read; a high level wins over the clear

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      pin_level_status_reg <= '0;
    end else if (rd_status) begin
      pin_level_status_reg <= pin_level;
    end else begin
      pin_level_status_reg <= pin_level_status_reg | pin_level;
    end
  end

  assign IRQ_O = |(pin_level_status_reg & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Operating state: only the fallback entry is modelled in detail

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      op_state <= OP_STANDBY;
    end else begin
      case (op_state)
        OP_FALLBACK: begin
          if (!fallback_ok) begin
            op_state <= OP_STANDBY;
          end
        end
        default: begin
          if (fallback_ok) begin
            op_state <= OP_FALLBACK;
          end
        end
      endcase
    end
  end

  assign OP_STATE_O = op_state;

  ////////////////////////////////////////////////////////////////////////////
  // Switch matrix

  logic combine_and;
  logic pin_path_ok;
  assign combine_and = hardware_config_reg &&
                       !(fallback_level && op_state == OP_FALLBACK);
  // Pins act in every state this block models; active also honours them
  assign pin_path_ok = 1'b1;

  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
          CHANNEL_ON_O[g] <= 1'b0;
        end else if (op_state == OP_FALLBACK) begin
          CHANNEL_ON_O[g] <= pin_level[g];
        end else if (combine_and) begin
          CHANNEL_ON_O[g] <= channel_switch_bit_n[g] && pin_level[g];
        end else begin
          CHANNEL_ON_O[g] <= channel_switch_bit_n[g] ||
                             (pin_level[g] && pin_path_ok);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_OR_MODE: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!hardware_config_reg && op_state != OP_FALLBACK) |=>
      CHANNEL_ON_O == ($past(channel_switch_bit_n) | $past(pin_level)))
    else $error("OR combination wrong");

  AST_AND_MODE: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (hardware_config_reg && op_state != OP_FALLBACK) |=>
      CHANNEL_ON_O == ($past(channel_switch_bit_n) & $past(pin_level)))
    else $error("AND combination wrong");

  AST_RESET_OR: assert property (
    @(posedge CORE_CLK_I)
    SYS_RST_I |=> !hardware_config_reg)
    else $error("combine-select not cleared by reset");

  AST_FALLBACK_PINS: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    op_state == OP_FALLBACK |=> CHANNEL_ON_O == $past(pin_level))
    else $error("fallback does not follow pins only");

  AST_PIN_WORKS: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (pin_level[0] && !hardware_config_reg) |=> CHANNEL_ON_O[0])
    else $error("pin failed to switch its channel");

  AST_FLAG_SET: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    pin_level[0] |=> pin_level_status_reg[0])
    else $error("pin-high flag not set");

  AST_FLAG_CLEAR: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (rd_status && !pin_level[0]) |=> !pin_level_status_reg[0])
    else $error("pin-high flag not cleared by read");

  AST_FLAG_KEEP: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (rd_status && pin_level[1]) |=> pin_level_status_reg[1])
    else $error("high level lost on read");

  AST_FALLBACK_ENTRY: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_state == OP_FALLBACK) |-> $past(fallback_ok))
    else $error("fallback entered without qualification");

  sequence ack_seq;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  AST_BUS_ACK: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    bus_req |=> ack_seq)
    else $error("bus ack not single cycle");

  // Read data must carry the flags as they stood before the clear
  AST_STATUS_READ: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    rd_status |=> WB_DAT_O[CHANNELS-1:0] == $past(pin_level_status_reg))
    else $error("status read returned wrong flags");

  AST_CFG_WRITE: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_en && WB_ADR_I == `OFS_HARDWARE_CONFIG_REG) |=>
      hardware_config_reg == $past(WB_DAT_I[`COMBINE_SELECT_BIT]))
    else $error("combine-select write lost");

  AST_SWITCH_WRITE: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_en && WB_ADR_I == `OFS_CHANNEL_SWITCH_REG) |=>
      channel_switch_bit_n == $past(WB_DAT_I[CHANNELS-1:0]))
    else $error("switch bit write lost");

  // Leaving fallback must not linger once the qualified level is gone
  AST_FALLBACK_EXIT: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (op_state == OP_FALLBACK && !fallback_ok) |=> op_state == OP_STANDBY)
    else $error("fallback state held without qualification");

endmodule

// ---- tb/chan_host_model.sv ----
// Host side model: register bus master and pin driver for the switch.
// Assumes a slave that answers one request at a time on clk_i.
`timescale 1ns/1ps

module chan_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o,
  output logic [3:0]       sel_o,
  output logic [3:0]       pins_o,
  output logic             fallback_o
);
  initial begin
    cyc_o      = 1'b0;
    stb_o      = 1'b0;
    we_o       = 1'b0;
    adr_o      = 8'h00;
    dat_o      = 32'h0;
    sel_o      = 4'h0;
    pins_o     = 4'h0;
    fallback_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse so stale values are never read back
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 4'hf;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    sel_o <= 4'h0;
  endtask

  task automatic drive(input logic [3:0] p, input logic f);
    @(posedge clk_i);
    pins_o     <= p;
    fallback_o <= f;
  endtask
endmodule

// ---- tb/chan_switch_matrix_tb_top.sv ----
// Self-checking bench for the channel input switch matrix.
// Assumes the host model drives bus and pins; fallback count cut to 8.
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"

module chan_switch_matrix_tb_top;
  import chan_switch_pkg::*;
  localparam int ACT = 8;
  logic        clk;
  logic        rst;
  logic        cyc, stb, we, ack, fb, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  sel, pins, chan;
  op_state_type st;
  int          mismatches;
  int          num_checks;
  int          cycles;

  chan_switch_matrix #(.CHANNELS(4), .ACT_CYCLES(ACT)) i_dut (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .DIRECT_CHANNEL_PIN_I(pins),
    .FALLBACK_PIN_I(fb), .CHANNEL_ON_O(chan), .OP_STATE_O(st), .IRQ_O(irq));

  chan_host_model i_host (
    .clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel), .pins_o(pins),
    .fallback_o(fb));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask

  // Pin path is three sync stages, the agreement register and the output register
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(chan, 32'h0);
    check(st, OP_STANDBY);
    check(irq, 32'h0);
    rd(`OFS_HARDWARE_CONFIG_REG, 32'h0);
    rd(8'h14, 32'h0);
  endtask

  task automatic t_or();
    wr(`OFS_CHANNEL_SWITCH_REG, 32'h5);
    i_host.drive(4'h6, 1'b0);
    settle();
    check(chan, 32'h7);
  endtask

  // Low and high pin levels must gate the enabled channels
  task automatic t_and();
    wr(`OFS_HARDWARE_CONFIG_REG, 32'h1);
    settle();
    check(chan, 32'h4);
    i_host.drive(4'h0, 1'b0);
    settle();
    check(chan, 32'h0);
    i_host.drive(4'hf, 1'b0);
    settle();
    check(chan, 32'h5);
    wr(`OFS_HARDWARE_CONFIG_REG, 32'h0);
  endtask

  task automatic t_flags();
    wr(`OFS_IRQ_MASK_REG, 32'h2);
    check(irq, 32'h1);
    i_host.drive(4'h0, 1'b0);
    settle();
    rd(`OFS_PIN_LEVEL_STATUS, 32'hf);
    rd(`OFS_PIN_LEVEL_STATUS, 32'h0);
    check(irq, 32'h0);
    i_host.drive(4'h2, 1'b0);
    settle();
    check(irq, 32'h1);
    rd(`OFS_PIN_LEVEL_STATUS, 32'h2);
    rd(`OFS_PIN_LEVEL_STATUS, 32'h2);
    i_host.drive(4'h0, 1'b0);
    settle();
    rd(`OFS_PIN_LEVEL_STATUS, 32'h2);
    rd(`OFS_PIN_LEVEL_STATUS, 32'h0);
  endtask

  // Short highs split by a low must not add up to the activation time
  task automatic t_fallback();
    wr(`OFS_HARDWARE_CONFIG_REG, 32'h1);
    i_host.drive(4'h3, 1'b1);
    repeat (ACT - 2) @(posedge clk);
    i_host.drive(4'h3, 1'b0);
    repeat (2) @(posedge clk);
    i_host.drive(4'h3, 1'b1);
    // Past the point where a count that survived the low would qualify
    repeat (ACT + 2) @(posedge clk);
    check(st == OP_FALLBACK, 32'h0);
    repeat (20) @(posedge clk);
    check(st, OP_FALLBACK);
    check(chan, 32'h3);
    rd(`OFS_STATE_REG, OP_FALLBACK);
    i_host.drive(4'h3, 1'b0);
    settle();
    check(st == OP_FALLBACK, 32'h0);
    check(chan, 32'h1);
  endtask

  initial begin
    rst        = 1'b1;
    mismatches = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_or();
    t_and();
    t_flags();
    t_fallback();
    close_out();
  end
endmodule
